//--- shared/rtc_pin_io_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers reached through the two-wire bus register port
// Notes: definitions only
`ifndef RTC_PIN_IO_REGS_SVH
`define RTC_PIN_IO_REGS_SVH

`define BATT_SWITCH_CTRL_OFS 8'h26
`define PIN_IO_CTRL_OFS 8'h27

`define BATT_SWITCH_CTRL_RST 5'h00
`define PIN_IO_CTRL_RST 8'h00
// pin drive register at reset: every pin released, drive levels low, irq b inactive
`define PIN_OUT_RST 8'h6a

// battery switch control fields
`define BSC_THRESH_BIT 0

// pin io control fields
`define PIO_CLK_DIS_BIT 7
`define PIO_PULL_BIT 6
`define PIO_SENSE_BIT 5
`define PIO_TYPE_BIT 4
`define PIO_STAMP_MODE_HI 3
`define PIO_STAMP_MODE_LO 2
`define PIO_IRQA_MODE_HI 1
`define PIO_IRQA_MODE_LO 0

// clock output frequency codes
`define COF_DISABLED 3'h7
`define COF_ONE_HZ 3'h6

// oscillator divider: 15 stages, 2048 oscillator periods per 16 Hz sample
`define DIV_WIDTH 15
`define SAMPLE_DIV_BITS 11
`define ONE_HZ_BIT 14

`endif

//--- shared/rtc_pin_io_pkg.sv
// Purpose: types shared by the pin io block
// Assumes: mode codes as held in the pin io control register
// Notes: constants live in rtc_pin_io_regs.svh
package rtc_pin_io_pkg;

    typedef enum logic [1:0] {
        STAMP_OFF = 2'h0,
        STAMP_IRQ_B = 2'h1,
        STAMP_CLK = 2'h2,
        STAMP_INPUT = 2'h3
    } stamp_mode_t;

    typedef enum logic [1:0] {
        IRQA_CLK = 2'h0,
        IRQA_BATT = 2'h1,
        IRQA_IRQ = 2'h2,
        IRQA_HIZ = 2'h3
    } irq_a_mode_t;

    typedef enum logic {
        SAMP_IDLE,
        SAMP_WINDOW
    } samp_state_t;

endpackage : rtc_pin_io_pkg

//--- hw/rtc_pin_io_and_battery_irq.sv
// Purpose: multi-function pin control and battery switch interrupt logic
// Assumes: osc_clk is the 32.768 kHz oscillator, sampled into the mclk domain
// Notes: output enables are active low; open-drain pins drive only 0
`timescale 1ns/1ns
`include "rtc_pin_io_regs.svh"

// Operation
// - threshold bit clear selects lower reference, set selects higher; clear at reset.
// - battery events reach output A or B only with that output's enable set.
// - battery switch flag stays set until software clears it explicitly.
// - each output shows battery event as pulse or as level following the flag.
// - in pulse mode every supply transition, either direction, fires an interrupt on A, flag set or not; B fires only on the return to main.
// - interrupt B is inactive on battery supply; drives only on main supply.
// - clock pin disable bit forces constant 0, else selected clock frequency.
// - pull-up strength bit clear selects weak pull-up, set selects strong.
// - sense bit clear means rising edge active, set means falling edge active.
// - stamp pin mode: 00 off, 01 interrupt B, 10 clock out, 11 input.
// - stamp pin output modes go Hi-Z on battery, push-pull on main.
// - input type bit only matters when stamp pin is in input mode.
// - direct input takes pin level with sense, ignored on battery.
// - switch detector samples at 16 Hz briefly, pull-up only then, both supplies.
// - active stamp input triggers stamps; with stop select it halts counting.
// - pin A mode: 00 clock, 01 battery indicator, 10 interrupt, 11 Hi-Z.
// - pin A interrupt mode is active-low open-drain on both supplies.
// - pin A clock mode is open-drain on main, Hi-Z on battery.
// - pin A indicator mode: Hi-Z on main, 0 on battery, ignores flags.
// - frequency code 111 gives static low on clock and stamp pins, Hi-Z on A.
module rtc_pin_io_and_battery_irq
    import rtc_pin_io_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic osc_clk,
    input wire logic on_battery,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic batt_irq_en_a,
    input wire logic batt_irq_en_b,
    input wire logic batt_level_mode_a,
    input wire logic batt_level_mode_b,
    input wire logic other_irq_a,
    input wire logic other_irq_b,
    input wire logic batt_flag_clear,
    input wire logic [2:0] clk_out_freq_sel,
    input wire logic stop_source_sel,
    input wire logic stamp_pin_in,
    output logic stamp_pin_out,
    output logic stamp_pin_oe_n,
    output logic stamp_pull_en,
    output logic switch_pullup_strength,
    output logic clk_pin_out,
    output logic clk_pin_oe_n,
    output logic irq_a_pin_out,
    output logic irq_a_pin_oe_n,
    output logic irq_out_b_n,
    output logic switch_threshold_sel,
    output logic batt_switch_flag,
    output logic stamp_event,
    output logic stamp_stop_req
);

    logic [4:0] bsc_q;
    logic [7:0] pio_q;
    logic [7:0] rdata_q;
    logic osc_s1_q, osc_s2_q, osc_s3_q;
    logic batt_s1_q, batt_s2_q, batt_s3_q;
    logic pin_s1_q, pin_s2_q;
    logic [`DIV_WIDTH-1:0] div_q;
    samp_state_t samp_q, samp_d;
    logic mech_q;
    logic lvl_q;
    logic flag_q;
    logic pulse_q;
    logic [7:0] out_q;

    // decode
    wire osc_tick = osc_s2_q & ~osc_s3_q;
    wire batt_edge = batt_s2_q ^ batt_s3_q;
    wire on_batt = batt_s2_q;
    wire wr_bsc = reg_wr && (reg_addr == `BATT_SWITCH_CTRL_OFS);
    wire wr_pio = reg_wr && (reg_addr == `PIN_IO_CTRL_OFS);
    wire clk_dis = pio_q[`PIO_CLK_DIS_BIT];
    wire sense_low = pio_q[`PIO_SENSE_BIT];
    wire mech_type = pio_q[`PIO_TYPE_BIT];
    stamp_mode_t stamp_mode;
    irq_a_mode_t irq_a_mode;
    assign stamp_mode = stamp_mode_t'(pio_q[`PIO_STAMP_MODE_HI:`PIO_STAMP_MODE_LO]);
    assign irq_a_mode = irq_a_mode_t'(pio_q[`PIO_IRQA_MODE_HI:`PIO_IRQA_MODE_LO]);
    wire in_mode = (stamp_mode == STAMP_INPUT);

    // selected clock from the oscillator or the divider chain
    logic clk_sel;
    always_comb begin
        case (clk_out_freq_sel)
            3'h0: clk_sel = osc_s2_q;
            3'h1: clk_sel = div_q[0];
            3'h2: clk_sel = div_q[1];
            3'h3: clk_sel = div_q[2];
            3'h4: clk_sel = div_q[3];
            3'h5: clk_sel = div_q[4];
            `COF_ONE_HZ: clk_sel = div_q[`ONE_HZ_BIT];
            default: clk_sel = 1'b0;
        endcase
    end
    wire cof_off = (clk_out_freq_sel == `COF_DISABLED);

    // battery interrupt sources
    wire batt_src_a = batt_level_mode_a ? flag_q : pulse_q;
    wire batt_src_b = batt_level_mode_b ? flag_q : pulse_q;
    wire irq_a_act = other_irq_a | (batt_irq_en_a & batt_src_a);
    wire irq_b_act = ~on_batt & (other_irq_b | (batt_irq_en_b & batt_src_b));

    // stamp input conditioning
    wire samp_strobe = osc_tick && (div_q[`SAMPLE_DIV_BITS-1:0] == '0);
    wire direct_ok = in_mode & ~mech_type & ~on_batt;
    wire raw_lvl = mech_type ? mech_q : pin_s2_q;
    wire act_lvl = sense_low ? ~raw_lvl : raw_lvl;
    wire lvl_d = (in_mode & (mech_type | direct_ok)) ? act_lvl : 1'b0;

    always_comb begin
        samp_d = samp_q;
        case (samp_q)
            SAMP_IDLE: if (in_mode && mech_type && samp_strobe) samp_d = SAMP_WINDOW;
            SAMP_WINDOW: if (osc_tick) samp_d = SAMP_IDLE; // one oscillator period
            default: samp_d = SAMP_IDLE;
        endcase
    end

    // pin drive, combined then registered
    logic [7:0] out_d;
    always_comb begin
        out_d = 8'hff;
        // [0] clk out, [1] clk oe_n, [2] a out, [3] a oe_n, [4] ts out, [5] ts oe_n
        out_d[0] = clk_dis ? 1'b0 : clk_sel;
        out_d[1] = on_batt;
        out_d[2] = 1'b0;
        case (irq_a_mode)
            IRQA_CLK: out_d[3] = on_batt | cof_off | clk_sel;
            IRQA_BATT: out_d[3] = ~on_batt;
            IRQA_IRQ: out_d[3] = ~irq_a_act;
            default: out_d[3] = 1'b1;
        endcase
        case (stamp_mode)
            STAMP_IRQ_B: begin
                out_d[4] = ~irq_b_act;
                out_d[5] = on_batt;
            end
            STAMP_CLK: begin
                out_d[4] = clk_sel;
                out_d[5] = on_batt;
            end
            default: begin
                out_d[4] = 1'b0;
                out_d[5] = 1'b1;
            end
        endcase
        out_d[6] = ~irq_b_act;
        out_d[7] = 1'b0;
    end

    // register file
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bsc_q <= `BATT_SWITCH_CTRL_RST;
            pio_q <= `PIN_IO_CTRL_RST;
        end else begin
            if (wr_bsc) bsc_q <= reg_wdata[4:0];
            if (wr_pio) pio_q <= reg_wdata;
        end
    end

    // unmapped reads return zero; reserved bits read zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `BATT_SWITCH_CTRL_OFS) rdata_q <= {3'h0, bsc_q};
            else if (reg_addr == `PIN_IO_CTRL_OFS) rdata_q <= pio_q;
            else rdata_q <= 8'h00;
        end
    end

    // synchronisers for pins and the oscillator
    // third flop only forms edges; nothing but flop 2 reads flop 1
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {osc_s1_q, osc_s2_q, osc_s3_q} <= 3'h0;
            {batt_s1_q, batt_s2_q, batt_s3_q} <= 3'h0;
            {pin_s1_q, pin_s2_q} <= 2'h0;
        end else begin
            {osc_s1_q, osc_s2_q, osc_s3_q} <= {osc_clk, osc_s1_q, osc_s2_q};
            {batt_s1_q, batt_s2_q, batt_s3_q} <= {on_battery, batt_s1_q, batt_s2_q};
            {pin_s1_q, pin_s2_q} <= {stamp_pin_in, pin_s1_q};
        end
    end

    // divider chain, runs on either supply
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) div_q <= '0;
        else if (osc_tick) div_q <= div_q + 1'b1;
    end

    // switch detector: pull-up for one period, sample at its end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            samp_q <= SAMP_IDLE;
            mech_q <= 1'b0;
        end else begin
            samp_q <= samp_d;
            if (samp_q == SAMP_WINDOW && osc_tick) mech_q <= pin_s2_q;
        end
    end

    // stamp input level and edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= 1'b0;
            stamp_event <= 1'b0;
            stamp_stop_req <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            stamp_event <= lvl_d & ~lvl_q;
            stamp_stop_req <= stop_source_sel & lvl_d;
        end
    end

    // battery flag and event pulse; a set beats a simultaneous clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            if (batt_edge && batt_s2_q) flag_q <= 1'b1;
            else if (batt_flag_clear) flag_q <= 1'b0;
            // pulse lasts until the next oscillator tick
            if (batt_edge) pulse_q <= 1'b1;
            else if (osc_tick) pulse_q <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= `PIN_OUT_RST;
            stamp_pull_en <= 1'b0;
            switch_pullup_strength <= 1'b0;
            switch_threshold_sel <= 1'b0;
        end else begin
            out_q <= out_d;
            stamp_pull_en <= (samp_d == SAMP_WINDOW);
            switch_pullup_strength <= pio_q[`PIO_PULL_BIT];
            switch_threshold_sel <= bsc_q[`BSC_THRESH_BIT];
        end
    end

    assign reg_rdata = rdata_q;
    assign batt_switch_flag = flag_q;
    assign clk_pin_out = out_q[0];
    assign clk_pin_oe_n = out_q[1];
    assign irq_a_pin_out = out_q[2];
    assign irq_a_pin_oe_n = out_q[3];
    assign stamp_pin_out = out_q[4];
    assign stamp_pin_oe_n = out_q[5];
    assign irq_out_b_n = out_q[6];

    // register and flag guards
    chk_thresh_follows_reg: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_bsc |=> ##1 (switch_threshold_sel == $past(reg_wdata[`BSC_THRESH_BIT], 2)))
        else $error("threshold bit");
    chk_pull_strength: assert property (@(posedge mclk) disable iff (!rst_n)
        switch_pullup_strength == $past(pio_q[`PIO_PULL_BIT])) else $error("pull strength");
    chk_flag_holds_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (flag_q && !batt_flag_clear) |=> flag_q) else $error("flag dropped");
    chk_flag_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        (batt_edge && batt_s2_q) |=> flag_q) else $error("flag not set");
    chk_edge_pulses: assert property (@(posedge mclk) disable iff (!rst_n)
        batt_edge |=> pulse_q) else $error("no pulse on transition");
    chk_pulse_ends: assert property (@(posedge mclk) disable iff (!rst_n)
        (pulse_q && osc_tick && !batt_edge) |=> !pulse_q) else $error("pulse too long");

    // interrupt pin guards
    chk_irq_b_battery: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(on_batt) |-> irq_out_b_n) else $error("irq b active on battery");
    chk_irq_b_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(!batt_irq_en_b && !other_irq_b) |-> irq_out_b_n)
        else $error("irq b not gated");
    chk_irq_a_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(irq_a_mode == IRQA_IRQ && !batt_irq_en_a && !other_irq_a) |-> irq_a_pin_oe_n)
        else $error("irq a not gated");
    chk_level_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(irq_a_mode == IRQA_IRQ && batt_irq_en_a && batt_level_mode_a && flag_q)
        |-> !irq_a_pin_oe_n) else $error("level irq not shown");
    chk_a_drives_irq: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(irq_a_mode == IRQA_IRQ && other_irq_a) |-> !irq_a_pin_oe_n)
        else $error("irq a not driven");
    chk_indicator_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        (irq_a_mode == IRQA_BATT) |=> (irq_a_pin_oe_n == !$past(on_batt)))
        else $error("indicator wrong");
    chk_a_clk_battery: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(irq_a_mode == IRQA_CLK && on_batt) |-> irq_a_pin_oe_n)
        else $error("clock on pin a while on battery");
    chk_a_clk_off: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(irq_a_mode == IRQA_CLK && cof_off) |-> irq_a_pin_oe_n)
        else $error("pin a driven with clock off");
    chk_a_hiz_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(irq_a_mode == IRQA_HIZ) |-> irq_a_pin_oe_n) else $error("pin a driven in off mode");

    // clock and stamp pin guards
    chk_clk_disable: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(clk_dis) |-> !clk_pin_out) else $error("clk pin not low");
    chk_stamp_hiz_batt: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(on_batt) |-> stamp_pin_oe_n) else $error("stamp pin driven on battery");
    chk_stamp_off_hiz: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(stamp_mode == STAMP_OFF) |-> stamp_pin_oe_n)
        else $error("stamp pin driven when off");
    chk_stamp_clk_off: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(stamp_mode == STAMP_CLK && cof_off) |-> !stamp_pin_out)
        else $error("stamp clock not static low");

    // stamp input guards
    chk_pull_window: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(stamp_pull_en) |-> $past(samp_strobe)) else $error("pull outside strobe");
    chk_pull_closes: assert property (@(posedge mclk) disable iff (!rst_n)
        (samp_q == SAMP_WINDOW && osc_tick) |=> !stamp_pull_en)
        else $error("pull window too long");
    chk_direct_battery: assert property (@(posedge mclk) disable iff (!rst_n)
        (on_batt && !mech_type) |=> !lvl_q) else $error("direct input on battery");
    chk_input_only: assert property (@(posedge mclk) disable iff (!rst_n)
        !in_mode |=> !lvl_q) else $error("input level outside input mode");
    chk_event_single: assert property (@(posedge mclk) disable iff (!rst_n)
        stamp_event |=> !stamp_event) else $error("stamp event too long");
    chk_stop_needs_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(stop_source_sel) |-> !stamp_stop_req) else $error("stop without select");

endmodule : rtc_pin_io_and_battery_irq

//--- test/rtc_switch_model.sv
// Purpose: oscillator, mechanical switch and far-end driver on the stamp pin
// Assumes: oscillator sped up so that the long sample period fits the run
// Notes: a released pin shows a toggling pattern, never a held value
`timescale 1ns/1ns
module rtc_switch_model #(
    parameter int OSC_HALF_NS = 20
) (
    output logic osc_clk,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic pull_en,
    input wire logic sw_closed,
    input wire logic drive_en,
    input wire logic drive_val,
    output logic pin_in
);
    logic flt = 1'b0;
    initial osc_clk = 1'b0;
    always #(OSC_HALF_NS) osc_clk = ~osc_clk;
    // no keeper on the pin, so an undriven pin wanders
    always #3 flt = ~flt;
    always_comb begin
        if (!pin_oe_n) begin
            pin_in = pin_out;
        end else if (drive_en) begin
            pin_in = drive_val;
        end else if (sw_closed) begin
            pin_in = 1'b0;
        end else if (pull_en) begin
            pin_in = 1'b1;
        end else begin
            pin_in = flt;
        end
    end
endmodule : rtc_switch_model

//--- test/test_rtc_pin_io_and_battery_irq.sv
// Purpose: self-checking bench for pin io and battery interrupt logic
// Assumes: oscillator runs at 10 mclk periods to keep the run short
// Notes: register reads are checked from a queue by a watcher process
`timescale 1ns/1ns
`include "rtc_pin_io_regs.svh"
module test_rtc_pin_io_and_battery_irq;
    logic mclk = 0, rst_n = 0, bat = 0, wr_s = 0, rd_s = 0, rd_d = 0;
    logic en_a = 0, en_b = 0, lv_a = 0, lv_b = 0, fclr = 0, stop = 0;
    logic sw = 0, dr_en = 0, dr_v = 0, hi = 0, lo = 0, oth_a = 0, oth_b = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, r;
    logic [2:0] cof = 3'h7;
    logic [7:0] exp_q[$];
    wire logic osc, pin_in, p_out, p_oe_n, pull, pstr, c_out, c_oe_n, a_out, a_oe_n;
    wire logic b_n, thr, flag, ev, stop_req;
    wire logic [7:0] rdata;
    int error_cnt = 0, checks_done = 0, ev_cnt = 0, b_low = 0, e0, n;

    always #2 mclk = ~mclk;

    rtc_switch_model #(.OSC_HALF_NS(20)) switch_u (.osc_clk(osc), .pin_out(p_out),
        .pin_oe_n(p_oe_n), .pull_en(pull), .sw_closed(sw), .drive_en(dr_en),
        .drive_val(dr_v), .pin_in(pin_in));

    rtc_pin_io_and_battery_irq dut_u (.mclk(mclk), .rst_n(rst_n), .osc_clk(osc),
        .on_battery(bat), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_rdata(rdata), .batt_irq_en_a(en_a), .batt_irq_en_b(en_b),
        .batt_level_mode_a(lv_a), .batt_level_mode_b(lv_b), .other_irq_a(oth_a),
        .other_irq_b(oth_b), .batt_flag_clear(fclr), .clk_out_freq_sel(cof),
        .stop_source_sel(stop), .stamp_pin_in(pin_in), .stamp_pin_out(p_out),
        .stamp_pin_oe_n(p_oe_n), .stamp_pull_en(pull), .switch_pullup_strength(pstr),
        .clk_pin_out(c_out), .clk_pin_oe_n(c_oe_n), .irq_a_pin_out(a_out),
        .irq_a_pin_oe_n(a_oe_n), .irq_out_b_n(b_n), .switch_threshold_sel(thr),
        .batt_switch_flag(flag), .stamp_event(ev), .stamp_stop_req(stop_req));

    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task test_done;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task wcyc(input int k);
        repeat (k) @(negedge mclk);
    endtask : wcyc

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wd = d;
        wr_s = 1;
        @(negedge mclk);
        wr_s = 0;
        wcyc(3);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        addr = a;
        rd_s = 1;
        exp_q.push_back(e);
        @(negedge mclk);
        rd_s = 0;
    endtask : rd

    // read data stands from the cycle after the request
    always @(posedge mclk) rd_d <= rd_s;
    always @(negedge mclk) if (rd_d) check("reg_rdata", rdata, exp_q.pop_front());
    always @(posedge mclk) begin
        if (ev === 1'b1) ev_cnt++;
        if (b_n === 1'b0) b_low++;
    end

    // stamp edge: returns the number of events seen after driving level v
    task edge_to(input logic v, output int d);
        e0 = ev_cnt;
        dr_v = v;
        wcyc(12);
        d = ev_cnt - e0;
    endtask : edge_to

    initial begin
        void'($urandom(32'h64a52a11));
        fork
            begin
                // two switch sample periods, about 41k cycles, plus margin
                #250000;
                error_cnt++;
                test_done();
            end
        join_none
        repeat (12) @(negedge mclk);
        rst_n = 1;
        wcyc(2);
        rd(`BATT_SWITCH_CTRL_OFS, 8'h00);
        rd(`PIN_IO_CTRL_OFS, 8'h00);
        check("thr", thr, 0);
        check("pstr", pstr, 0);
        check("p_oe_n", p_oe_n, 1);
        check("a_oe_n", a_oe_n, 1);
        check("c_out", c_out, 0);
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom());
            wr(`BATT_SWITCH_CTRL_OFS, r);
            rd(`BATT_SWITCH_CTRL_OFS, r & 8'h1f);
            check("thr", thr, r[0]);
            r = 8'($urandom());
            wr(`PIN_IO_CTRL_OFS, r);
            rd(`PIN_IO_CTRL_OFS, r);
            check("pstr", pstr, r[6]);
        end
        wr(`BATT_SWITCH_CTRL_OFS, 8'h00);
        wr(8'h28, 8'hff);
        rd(8'h28, 8'h00);
        rd(`BATT_SWITCH_CTRL_OFS, 8'h00);
        cof = 3'h0;
        wr(`PIN_IO_CTRL_OFS, 8'h80);
        repeat (20) begin
            @(negedge mclk);
            check("c_out", {c_oe_n, c_out}, 0);
        end
        wr(`PIN_IO_CTRL_OFS, 8'h00);
        repeat (40) begin
            @(negedge mclk);
            hi = hi | (c_out === 1'b1);
            lo = lo | (a_oe_n === 1'b0);
        end
        check("c_run", hi, 1);
        check("a_clk", lo, 1);
        en_a = 1;
        en_b = 1;
        lv_a = 1;
        wr(`PIN_IO_CTRL_OFS, 8'h06);
        check("p_oe_n", p_oe_n, 0);
        check("b_idle", {b_n, p_out}, 8'h03);
        oth_a = 1;
        oth_b = 1;
        wcyc(4);
        check("a_oth", a_oe_n, 0);
        check("a_out", a_out, 0);
        check("b_oth", {b_n, p_out}, 8'h00);
        oth_a = 0;
        oth_b = 0;
        wcyc(4);
        bat = 1;
        wcyc(8);
        check("flag", flag, 1);
        check("a_lvl", a_oe_n, 0);
        check("p_oe_n", p_oe_n, 1);
        check("b_n", b_n, 1);
        wcyc(30);
        check("flag", flag, 1);
        check("a_lvl", a_oe_n, 0);
        b_low = 0;
        bat = 0;
        wcyc(30);
        check("b_pulse", b_low > 0, 1);
        check("b_n", b_n, 1);
        check("flag", flag, 1);
        @(negedge mclk) fclr = 1;
        @(negedge mclk) fclr = 0;
        wcyc(4);
        check("flag", flag, 0);
        check("a_lvl", a_oe_n, 1);
        en_a = 0;
        en_b = 0;
        b_low = 0;
        bat = 1;
        wcyc(30);
        check("a_off", a_oe_n, 1);
        bat = 0;
        wcyc(30);
        check("b_off", b_low, 0);
        wr(`PIN_IO_CTRL_OFS, 8'h01);
        check("ind", a_oe_n, 1);
        bat = 1;
        wcyc(8);
        check("ind", a_oe_n, 0);
        wr(`PIN_IO_CTRL_OFS, 8'h08);
        repeat (20) begin
            @(negedge mclk);
            check("bat_hiz", {c_oe_n, a_oe_n, p_oe_n}, 8'h07);
        end
        // leave battery only after the pin is an input, so no driven clock is sampled
        dr_en = 1;
        stop = 1;
        wr(`PIN_IO_CTRL_OFS, 8'h0c);
        bat = 0;
        wcyc(4);
        edge_to(1, n);
        check("ev_rise", n, 1);
        check("stop_req", stop_req, 1);
        edge_to(0, n);
        check("ev_fall", n, 0);
        wr(`PIN_IO_CTRL_OFS, 8'h2c);
        edge_to(1, n);
        edge_to(0, n);
        check("ev_fall", n, 1);
        bat = 1;
        edge_to(1, n);
        edge_to(0, n);
        check("ev_bat", n, 0);
        dr_en = 0;
        sw = 1;
        wr(`PIN_IO_CTRL_OFS, 8'h5c);
        n = 0;
        while (pull !== 1'b1 && n < 25000) begin
            @(negedge mclk);
            n++;
        end
        check("pull_on", pull, 1);
        n = 0;
        while (pull === 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        check("pull_win", n >= 8 && n <= 12, 1);
        wcyc(4);
        check("sw_closed", stop_req, 0);
        sw = 0;
        n = 0;
        while (pull !== 1'b1 && n < 25000) begin
            @(negedge mclk);
            n++;
        end
        while (pull === 1'b1 && n < 25020) begin
            @(negedge mclk);
            n++;
        end
        wcyc(4);
        check("sw_open", stop_req, 1);
        bat = 0;
        // unused clock outputs switched off
        cof = 3'h7;
        wr(`PIN_IO_CTRL_OFS, 8'h00);
        check("a_oe_n", a_oe_n, 1);
        check("c_out", c_out, 0);
        test_done();
    end
endmodule : test_rtc_pin_io_and_battery_irq
